// ---- rtl/frfr_top.sv ----
// frame relay link framer: apb registers, transmit framer and interrupt logic
//
// Decided for this implementation: the register offsets and the APB register port.
`include "frfr_params.svh"

//****************************************************************
// frame relay link framer
//****************************************************************
// Function
// - between frames the transmitter sends back-to-back flags 01111110
// - information fields of 1600 octets are sent and received
// - maximum information length is a register, reset to 1600
// - address field is exactly two octets right after the opening flag
// - extension bit is 0 in first address octet, 1 in second
// - received frames with a clear second extension bit are invalid
// - the address is always read as a connection identifier
// - congestion control sets forward and backward bits, discard bit is software
// - received congestion bits raise an event so the user can slow down
// - management frames on identifier 1023 may be passed or dropped
module frfr_top
  import frfr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             TX_LINE,
  input  wire logic        RX_LINE,
  output logic             LINE_STB,
  output logic             IRQ
);

  localparam frfr_top_t TOP_RST = '{
    txst:   FRFR_TX_FLAG,
    sr:     `FRFR_FLAG,
    maxlen: `FRFR_MAXLEN_RST,
    default: '0
  };

  frfr_top_t   r;
  frfr_top_t   n;
  logic        acc;
  logic        setup;
  logic        hit;
  logic [31:0] rd_val;
  logic [5:0]  ev_set;
  logic [5:0]  ev_clr;
  logic        boundary;

  frfr_rx_if rxi ();

  frfr_rx u_rx (
    .clk   (CLK),
    .rst_n (RST_N),
    .rxb   (rxi.rx)
  );

  assign rxi.bit_en    = r.stb;
  assign rxi.line_bit  = RX_LINE;
  assign rxi.cllm_drop = r.ctrl[`FRFR_CTRL_CLLM];
  assign rxi.maxlen    = r.maxlen;

  assign acc      = PSEL & PENABLE;
  assign setup    = PSEL & ~PENABLE;
  assign boundary = r.stb && r.ones != 3'h5 && r.bcnt == 3'h7;

  //****************************************************************
  // register read mux and decode
  //****************************************************************
  always_comb
  begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (PADDR)
      `FRFR_A_CTRL:   rd_val = {27'h0, r.ctrl};
      `FRFR_A_DLCI:   rd_val = {22'h0, r.dlci};
      `FRFR_A_MAXLEN: rd_val = {16'h0, r.maxlen};
      `FRFR_A_STAT:   rd_val = {29'h0, r.txst != FRFR_TX_FLAG, r.rxd_full, r.txh_full};
      `FRFR_A_RXDATA: rd_val = {23'h0, r.rxd};
      `FRFR_A_RXADDR: rd_val = {19'h0, rxi.de, rxi.becn, rxi.fecn, rxi.dlci};
      `FRFR_A_ISTAT:  rd_val = {26'h0, r.ev};
      `FRFR_A_IEN:    rd_val = {26'h0, r.ien};
      `FRFR_A_TXDATA: rd_val = 32'h0000_0000;
      `FRFR_A_ICLR:   rd_val = 32'h0000_0000;
      default:        hit = 1'b0;
    endcase
  end

  //****************************************************************
  // next state
  //****************************************************************
  always_comb
  begin
    n = r;
    ev_set = 6'h00;
    ev_clr = 6'h00;

    // line bit rate strobe from the clock divider
    n.stb = (r.div == 7'(`FRFR_BIT_DIV - 1));
    n.div = n.stb ? 7'h00 : r.div + 7'h01;

    // transmit shifter, one line bit per strobe, lsb first
    if (r.stb)
    begin
      if (r.ones == 3'h5)
      begin
        // also covers five ones at the end of the last octet, before the flag
        n.line = 1'b0;
        n.ones = 3'h0;
      end
      else
      begin
        n.line = r.sr[0];
        // flag bits are never counted, so flags are never broken up
        n.ones = (r.txst != FRFR_TX_FLAG && r.sr[0]) ? r.ones + 3'h1 : 3'h0;
        n.sr = {1'b0, r.sr[7:1]};
        n.bcnt = r.bcnt + 3'h1;
      end
    end

    if (boundary)
    begin
      unique case (r.txst)
        FRFR_TX_FLAG:
        begin
          if (r.ctrl[`FRFR_CTRL_TXEN] && r.txh_full)
          begin
            n.txst = FRFR_TX_ADR1;
            n.sr = {r.dlci[9:4], r.ctrl[`FRFR_CTRL_CR], 1'b0};
            n.icnt = 16'h0000;
            n.last_sent = 1'b0;
          end
          else
            n.sr = `FRFR_FLAG;
        end
        FRFR_TX_ADR1:
        begin
          n.txst = FRFR_TX_ADR2;
          // congestion marks both directions; discard bit set by software
          n.sr = {r.dlci[3:0], r.ctrl[`FRFR_CTRL_CONG], r.ctrl[`FRFR_CTRL_CONG],
                  r.ctrl[`FRFR_CTRL_DE], 1'b1};
        end
        FRFR_TX_ADR2, FRFR_TX_DATA:
        begin
          if (r.txst == FRFR_TX_DATA && (r.last_sent || r.icnt >= r.maxlen))
          begin
            // closing flag; a frame cut at the limit reports an error
            n.txst = FRFR_TX_FLAG;
            n.sr = `FRFR_FLAG;
            ev_set[`FRFR_EV_TXDONE] = 1'b1;
            ev_set[`FRFR_EV_TXERR] = ~r.last_sent;
          end
          else if (r.txh_full)
          begin
            n.txst = FRFR_TX_DATA;
            n.sr = r.txh[7:0];
            n.last_sent = r.txh[`FRFR_TXD_LAST];
            n.txh_full = 1'b0;
            n.icnt = r.icnt + 16'h0001;
          end
          else
          begin
            // no octet in time: the line cannot wait, so close early
            n.txst = FRFR_TX_FLAG;
            n.sr = `FRFR_FLAG;
            ev_set[`FRFR_EV_TXERR] = 1'b1;
          end
        end
      endcase
    end

    // register writes take effect at the end of the access phase
    if (acc && PWRITE)
    begin
      case (PADDR)
        `FRFR_A_CTRL:   n.ctrl = PWDATA[4:0];
        `FRFR_A_DLCI:   n.dlci = PWDATA[9:0];
        `FRFR_A_MAXLEN: n.maxlen = PWDATA[15:0];
        `FRFR_A_TXDATA:
        begin
          // a write to a full holding register is ignored; poll the status first
          if (!n.txh_full)
          begin
            n.txh = PWDATA[8:0];
            n.txh_full = 1'b1;
          end
        end
        `FRFR_A_ICLR:   ev_clr = PWDATA[5:0];
        `FRFR_A_IEN:    n.ien = PWDATA[5:0];
        default:        n.ien = r.ien;
      endcase
    end

    // reading received data frees the holding register
    if (acc && !PWRITE && PADDR == `FRFR_A_RXDATA)
      n.rxd_full = 1'b0;

    if (rxi.oct_valid)
    begin
      ev_set[`FRFR_EV_RXOVR] = n.rxd_full;
      n.rxd = {rxi.oct_last, rxi.oct_data};
      n.rxd_full = 1'b1;
    end
    ev_set[`FRFR_EV_RXOK] = rxi.frm_ok;
    ev_set[`FRFR_EV_RXERR] = rxi.frm_err;
    ev_set[`FRFR_EV_RXCONG] = rxi.frm_ok & (rxi.fecn | rxi.becn);

    // a new event wins over a clear in the same cycle
    n.ev = (r.ev & ~ev_clr) | ev_set;

    if (setup)
      n.prdata = rd_val;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      r <= TOP_RST;
    else
      r <= n;
  end

  assign PRDATA   = r.prdata;
  assign PREADY   = 1'b1;
  assign PSLVERR  = acc & ~hit;
  assign TX_LINE  = r.line;
  assign LINE_STB = r.stb;
  assign IRQ      = |(r.ev & r.ien);

  //****************************************************************
  // checks
  //****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  idle_flag_a: assert property (
    (boundary && r.txst == FRFR_TX_FLAG && !(r.ctrl[`FRFR_CTRL_TXEN] && r.txh_full))
    |=> r.sr == `FRFR_FLAG && r.txst == FRFR_TX_FLAG)
    else $error("idle line not filled with a flag");

  stuff_zero_a: assert property (
    (r.stb && r.ones == 3'h5) |=> !r.line && r.ones == 3'h0 && $stable(r.sr))
    else $error("no zero after five ones");

  addr_first_a: assert property (
    (boundary && r.txst == FRFR_TX_FLAG && r.ctrl[`FRFR_CTRL_TXEN] && r.txh_full)
    |=> r.txst == FRFR_TX_ADR1 && !r.sr[0] && r.sr[7:2] == r.dlci[9:4])
    else $error("first address octet wrong");

  addr_second_a: assert property (
    (boundary && r.txst == FRFR_TX_ADR1) |=> r.txst == FRFR_TX_ADR2 && r.sr[0] &&
    r.sr[7:4] == r.dlci[3:0] && r.sr[3] == r.ctrl[`FRFR_CTRL_CONG])
    else $error("second address octet wrong");

  tx_len_a: assert property (
    (boundary && r.txst == FRFR_TX_DATA && r.icnt >= r.maxlen)
    |=> r.txst == FRFR_TX_FLAG ##1 r.ev[`FRFR_EV_TXDONE])
    else $error("frame not closed at length limit");

  event_sticky_a: assert property (
    (ev_set != 6'h00) |=> ((r.ev & $past(ev_set)) == $past(ev_set)))
    else $error("event lost against a clear");

  apb_err_a: assert property (
    (acc && !hit) |-> PSLVERR ##1 $stable(r.ctrl) && $stable(r.ien))
    else $error("unmapped access not refused");

  tx_frame_c: cover property (r.ev[`FRFR_EV_TXDONE] && !r.ev[`FRFR_EV_TXERR]);
  tx_stuff_c: cover property (r.stb && r.ones == 3'h5 && r.txst == FRFR_TX_DATA);
  rx_cong_c: cover property (r.ev[`FRFR_EV_RXCONG]);

endmodule

// ---- rtl/frfr_params.svh ----
// constants of the frame relay link framer: timing, offsets, fields, reset values
`ifndef FRFR_PARAMS_SVH
`define FRFR_PARAMS_SVH

`define FRFR_CLK_KHZ      125000
`define FRFR_LINE_KBPS    2048
// clocks per line bit, rounded down so the line never runs slower than asked
`define FRFR_BIT_DIV      (`FRFR_CLK_KHZ / `FRFR_LINE_KBPS)

`define FRFR_FLAG         8'h7E
`define FRFR_MAXLEN_RST   16'h0640
`define FRFR_CLLM_DLCI    10'h3FF

`define FRFR_A_CTRL       8'h00
`define FRFR_A_DLCI       8'h04
`define FRFR_A_MAXLEN     8'h08
`define FRFR_A_TXDATA     8'h0C
`define FRFR_A_STAT       8'h10
`define FRFR_A_RXDATA     8'h14
`define FRFR_A_RXADDR     8'h18
`define FRFR_A_ISTAT      8'h1C
`define FRFR_A_ICLR       8'h20
`define FRFR_A_IEN        8'h24

`define FRFR_CTRL_TXEN    0
`define FRFR_CTRL_CONG    1
`define FRFR_CTRL_DE      2
`define FRFR_CTRL_CR      3
`define FRFR_CTRL_CLLM    4
`define FRFR_TXD_LAST     8

`define FRFR_EV_TXDONE    0
`define FRFR_EV_TXERR     1
`define FRFR_EV_RXOK      2
`define FRFR_EV_RXERR     3
`define FRFR_EV_RXCONG    4
`define FRFR_EV_RXOVR     5

`endif

// ---- rtl/frfr_pkg.sv ----
// types of the frame relay link framer
`include "frfr_params.svh"
package frfr_pkg;

  typedef enum logic [3:0] {
    FRFR_TX_FLAG = 4'b0001,
    FRFR_TX_ADR1 = 4'b0010,
    FRFR_TX_ADR2 = 4'b0100,
    FRFR_TX_DATA = 4'b1000
  } frfr_txst_t;

  typedef struct packed {
    logic [6:0]  div;
    logic        stb;
    logic [4:0]  ctrl;
    logic [9:0]  dlci;
    logic [15:0] maxlen;
    logic [8:0]  txh;
    logic        txh_full;
    frfr_txst_t  txst;
    logic [7:0]  sr;
    logic [2:0]  bcnt;
    logic [2:0]  ones;
    logic        last_sent;
    logic [15:0] icnt;
    logic        line;
    logic [8:0]  rxd;
    logic        rxd_full;
    logic [5:0]  ev;
    logic [5:0]  ien;
    logic [31:0] prdata;
  } frfr_top_t;

  typedef struct packed {
    logic [7:0]  win;
    logic [2:0]  ones;
    logic        hunt;
    logic [7:0]  sr;
    logic [2:0]  bcnt;
    logic [7:0]  pend;
    logic        pend_v;
    logic [15:0] ocnt;
    logic        err;
    logic        drop;
    logic [9:0]  dlci;
    logic        fecn;
    logic        becn;
    logic        de;
    logic        ov;
    logic [7:0]  od;
    logic        ol;
    logic        fok;
    logic        ferr;
  } frfr_rx_t;

endpackage

// ---- rtl/frfr_rx_if.sv ----
// link between the framer core and its receive deframer
interface frfr_rx_if;
  logic        bit_en;
  logic        line_bit;
  logic        cllm_drop;
  logic [15:0] maxlen;
  logic        oct_valid;
  logic [7:0]  oct_data;
  logic        oct_last;
  logic        frm_ok;
  logic        frm_err;
  logic [9:0]  dlci;
  logic        fecn;
  logic        becn;
  logic        de;

  modport rx (input bit_en, line_bit, cllm_drop, maxlen,
              output oct_valid, oct_data, oct_last, frm_ok, frm_err, dlci, fecn, becn, de);
  modport core (output bit_en, line_bit, cllm_drop, maxlen,
                input oct_valid, oct_data, oct_last, frm_ok, frm_err, dlci, fecn, becn, de);
endinterface

// ---- rtl/frfr_rx.sv ----
// receive deframer: flag hunt, zero removal, address check, octet delivery
`include "frfr_params.svh"
module frfr_rx
  import frfr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  frfr_rx_if.rx     rxb
);

  localparam frfr_rx_t RX_RST = '{hunt: 1'b1, default: '0};

  frfr_rx_t   r;
  frfr_rx_t   n;
  logic [7:0] wnew;
  logic [7:0] octet;
  logic       take;

  //****************************************************************
  // next state
  //****************************************************************
  always_comb
  begin
    n = r;
    n.ov = 1'b0;
    n.fok = 1'b0;
    n.ferr = 1'b0;
    take = 1'b0;
    // bits arrive lsb first, newest bit enters at the top
    wnew = {rxb.line_bit, r.win[7:1]};
    octet = {rxb.line_bit, r.sr[7:1]};
    if (rxb.bit_en)
    begin
      n.win = wnew;
      n.ones = rxb.line_bit ? ((r.ones == 3'h7) ? r.ones : r.ones + 3'h1) : 3'h0;
      if (wnew == `FRFR_FLAG)
      begin
        // a flag closes the frame; the held octet is its last one
        if (!r.hunt && r.ocnt != 16'h0000 && !r.drop)
        begin
          if (r.err || r.bcnt != 3'h7 || r.ocnt < 16'h0003)
            n.ferr = 1'b1;
          else
          begin
            n.fok = 1'b1;
            n.ov = 1'b1;
            n.od = r.pend;
            n.ol = 1'b1;
          end
        end
        n.hunt = 1'b0;
        n.bcnt = 3'h0;
        n.ocnt = 16'h0000;
        n.err = 1'b0;
        n.drop = 1'b0;
        n.pend_v = 1'b0;
      end
      else if (r.ones >= 3'h6 && rxb.line_bit)
      begin
        // seven ones: abort, hunt for the next flag
        n.hunt = 1'b1;
        if (!r.hunt && r.ocnt != 16'h0000 && !r.drop)
          n.ferr = 1'b1;
      end
      else if (r.ones == 3'h5 && !rxb.line_bit)
      begin
        n.sr = r.sr; // inserted zero is removed
      end
      else if (!r.hunt)
      begin
        take = 1'b1;
        n.sr = octet;
        n.bcnt = r.bcnt + 3'h1;
        if (r.bcnt == 3'h7)
        begin
          if (r.ocnt != 16'hFFFF)
            n.ocnt = r.ocnt + 16'h0001;
          // address is always taken as a connection identifier
          if (r.ocnt == 16'h0000)
          begin
            n.dlci[9:4] = octet[7:2];
            n.err = r.err | octet[0];
          end
          else if (r.ocnt == 16'h0001)
          begin
            n.dlci[3:0] = octet[7:4];
            n.fecn = octet[3];
            n.becn = octet[2];
            n.de = octet[1];
            // longer address forms are not handled and count as bad frames
            n.err = r.err | ~octet[0];
            n.drop = rxb.cllm_drop && {r.dlci[9:4], octet[7:4]} == `FRFR_CLLM_DLCI;
          end
          else
          begin
            if (r.ocnt - 16'h0001 > rxb.maxlen)
              n.err = 1'b1;
            if (r.pend_v && !n.err && !r.drop)
            begin
              n.ov = 1'b1;
              n.od = r.pend;
              n.ol = 1'b0;
            end
            n.pend = octet;
            n.pend_v = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= RX_RST;
    else
      r <= n;
  end

  assign rxb.oct_valid = r.ov;
  assign rxb.oct_data  = r.od;
  assign rxb.oct_last  = r.ol;
  assign rxb.frm_ok    = r.fok;
  assign rxb.frm_err   = r.ferr;
  assign rxb.dlci      = r.dlci;
  assign rxb.fecn      = r.fecn;
  assign rxb.becn      = r.becn;
  assign rxb.de        = r.de;

  //****************************************************************
  // checks
  //****************************************************************
  ea_check_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && r.bcnt == 3'h7 && ((r.ocnt == 16'h0000 && r.sr[1]) ||
     (r.ocnt == 16'h0001 && !r.sr[1]))) |=> r.err ##1 !r.fok)
    else $error("bad address extension bit not flagged");

  cllm_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.drop |=> !r.ov && !r.fok && !r.ferr)
    else $error("dropped management frame was delivered");

  rx_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!r.hunt && {1'b0, r.ocnt} > {1'b0, rxb.maxlen} + 17'h00002) |-> r.err)
    else $error("overlong received frame not flagged");

  abort_hunt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rxb.bit_en && r.ones == 3'h6 && rxb.line_bit) |=> r.hunt && r.bcnt == $past(r.bcnt))
    else $error("seven ones did not abort");

  rx_ok_c: cover property (@(posedge clk) r.fok);
  rx_err_c: cover property (@(posedge clk) r.ferr);

endmodule

// ---- tb/frfr_line_model.sv ----
// far-end line equipment: sends framed octets on the receive line, deframes the transmit line
`include "frfr_params.svh"
module frfr_line_model
(
  input  wire logic clk,
  input  wire logic line_stb,
  input  wire logic tx_line,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       sq[$];
  logic       bits[$];
  logic [7:0] got[$];
  logic [7:0] win;
  logic [2:0] fi;
  int         ones;
  int         nflag;
  int         nfrm;

  initial
  begin
    rx_line = 1'b0;
    fi = 3'h0;
    win = 8'h00;
    ones = 0;
    nflag = 0;
    nfrm = 0;
  end

  //****************************************************************
  // send side
  //****************************************************************
  // no length limit on frames queued here
  task automatic send(input logic [7:0] oct[$]);
    int k;
    int i;
    int c;
    c = 0;
    for (k = 0; k < oct.size(); k++)
    begin
      for (i = 0; i < 8; i++)
      begin
        sq.push_back(oct[k][i]);
        c = oct[k][i] ? c + 1 : 0;
        if (c == 5)
        begin
          sq.push_back(1'b0);
          c = 0;
        end
      end
    end
  endtask

  // a frame starts only on a flag boundary, so idle fill is always whole flags
  always @(posedge clk)
  begin
    if (line_stb)
    begin
      if (sq.size() != 0 && fi == 3'h0)
        rx_line <= sq.pop_front();
      else
      begin
        rx_line <= 1'(`FRFR_FLAG >> fi);
        fi <= fi + 3'h1;
      end
    end
  end

  //****************************************************************
  // receive side
  //****************************************************************
  // management frames are passed through like any other
  always @(posedge clk)
  begin
    if (line_stb)
    begin
      win = {tx_line, win[7:1]};
      if (win == `FRFR_FLAG)
      begin
        nflag++;
        if (bits.size() > 7)
        begin
          repeat (7) void'(bits.pop_back());
          if (bits.size() % 8 == 0)
          begin
            got.delete();
            for (int j = 0; j < bits.size() / 8; j++)
              got.push_back({bits[8*j+7], bits[8*j+6], bits[8*j+5], bits[8*j+4],
                             bits[8*j+3], bits[8*j+2], bits[8*j+1], bits[8*j]});
            nfrm++;
          end
        end
        bits.delete();
        ones = 0;
      end
      else if (ones == 5 && !tx_line)
        ones = 0;
      else
      begin
        bits.push_back(tx_line);
        ones = tx_line ? ones + 1 : 0;
      end
    end
  end
endmodule

// ---- tb/frfr_top_test.sv ----
// self-checking bench of the frame relay link framer
`include "frfr_params.svh"
module frfr_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        wr;
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } frfr_row_t;

  localparam int NROW = 9;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_line;
  logic        rx_line;
  logic        line_stb;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  oq[$];
  logic [8:0]  tq[$];
  int          miscompares = 0;
  int          tests_run = 0;

  frfr_row_t rows [NROW] = '{
    '{1'b0, `FRFR_A_CTRL,   32'h0, 32'h0, 1'b0},
    '{1'b0, `FRFR_A_MAXLEN, 32'h0, 32'h0000_0640, 1'b0},
    '{1'b0, `FRFR_A_DLCI,   32'h0, 32'h0, 1'b0},
    '{1'b0, `FRFR_A_IEN,    32'h0, 32'h0, 1'b0},
    '{1'b0, `FRFR_A_STAT,   32'h0, 32'h0, 1'b0},
    '{1'b1, `FRFR_A_DLCI,   32'hFFFF_FFFF, 32'h0000_03FF, 1'b0},
    '{1'b1, `FRFR_A_MAXLEN, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{1'b1, `FRFR_A_ISTAT,  32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b1, 8'h28,          32'hFFFF_FFFF, 32'h0, 1'b1}
  };

  always #4 clk = ~clk;

  frfr_top dut_u (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_LINE(tx_line), .RX_LINE(rx_line), .LINE_STB(line_stb), .IRQ(irq)
  );

  frfr_line_model far_u (.clk(clk), .line_stb(line_stb), .tx_line(tx_line), .rx_line(rx_line));

  //****************************************************************
  // helpers
  //****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waits for pready as long as it takes; only the watchdog ends a hung access
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reads until the masked bits equal v or 4000 reads have passed; a line octet takes about 500 clocks
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while ((rd & m) !== v && n < 4000);
    chk(rd & m, v);
  endtask

  task txf(input logic [8:0] t[$]);
    int f;
    int n;
    f = far_u.nfrm;
    n = 0;
    foreach (t[i])
    begin
      poll(`FRFR_A_STAT, 32'h1, 32'h0);
      apb(1'b1, `FRFR_A_TXDATA, {23'h0, t[i]});
    end
    while (far_u.nfrm == f && n < 8000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task stop_test;
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  //****************************************************************
  // main sequence
  //****************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    chk(tx_line, 1'b0);
    chk(irq, 1'b0);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        apb(1'b1, rows[i].adr, rows[i].wd);
      apb(1'b0, rows[i].adr, 32'h0);
      chk(rd, rows[i].exp);
      chk(er, rows[i].err);
      chk(pready, 1'b1);
    end
    $display("test registers done");

    repeat (61 * 32) @(posedge clk);
    chk(far_u.nflag >= 3, 1'b1);
    chk(far_u.nfrm, 32'd0);
    $display("test idle fill done");

    // congestion and discard bits set, identifier chosen with mixed bits
    apb(1'b1, `FRFR_A_ICLR, 32'h3F);
    apb(1'b1, `FRFR_A_DLCI, 32'h2A5);
    apb(1'b1, `FRFR_A_CTRL, 32'h7);
    tq = '{9'h0FF, 9'h07E, 9'h101};
    txf(tq);
    oq = '{8'hA8, 8'h5F, 8'hFF, 8'h7E, 8'h01};
    chk(far_u.got.size(), 32'd5);
    foreach (oq[i])
      chk(far_u.got[i], oq[i]);
    poll(`FRFR_A_ISTAT, 32'h1, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `FRFR_A_IEN, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, `FRFR_A_ICLR, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    $display("test transmit done");

    // no end mark: the limit closes the frame
    apb(1'b1, `FRFR_A_MAXLEN, 32'h2);
    apb(1'b1, `FRFR_A_ICLR, 32'h3F);
    tq = '{9'h011, 9'h022};
    txf(tq);
    chk(far_u.got.size(), 32'd4);
    chk(far_u.got[3], 8'h22);
    apb(1'b0, `FRFR_A_ISTAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    $display("test length limit done");

    apb(1'b1, `FRFR_A_ICLR, 32'h3F);
    apb(1'b1, `FRFR_A_CTRL, 32'h0);
    oq = '{8'h54, 8'h59, 8'hFC, 8'h3F};
    far_u.send(oq);
    poll(`FRFR_A_STAT, 32'h2, 32'h2);
    apb(1'b0, `FRFR_A_RXDATA, 32'h0);
    chk(rd, 32'h0FC);
    poll(`FRFR_A_STAT, 32'h2, 32'h2);
    apb(1'b0, `FRFR_A_RXDATA, 32'h0);
    chk(rd, 32'h13F);
    poll(`FRFR_A_ISTAT, 32'h4, 32'h4);
    apb(1'b0, `FRFR_A_RXADDR, 32'h0);
    chk(rd, 32'h555);
    apb(1'b0, `FRFR_A_ISTAT, 32'h0);
    chk(rd & 32'h1C, 32'h14);
    $display("test receive done");

    apb(1'b1, `FRFR_A_ICLR, 32'h3F);
    oq = '{8'h54, 8'h58, 8'hAA};
    far_u.send(oq);
    poll(`FRFR_A_ISTAT, 32'h8, 32'h8);
    chk(rd & 32'h4, 32'h0);
    $display("test bad extension done");

    // management identifier dropped without any event
    apb(1'b1, `FRFR_A_ICLR, 32'h3F);
    apb(1'b1, `FRFR_A_CTRL, 32'h10);
    oq = '{8'hFC, 8'hF1, 8'h33};
    far_u.send(oq);
    repeat (61 * 64) @(posedge clk);
    apb(1'b0, `FRFR_A_ISTAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `FRFR_A_STAT, 32'h0);
    chk(rd & 32'h2, 32'h0);
    $display("test management drop done");

    apb(1'b1, `FRFR_A_MAXLEN, 32'h7);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(tx_line, 1'b0);
    chk(line_stb, 1'b0);
    chk(irq, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `FRFR_A_MAXLEN, 32'h0);
    chk(rd, 32'h640);
    apb(1'b0, `FRFR_A_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule
